// ### verilog/pbs_pkg.sv
// constants and types shared by the burst memory device and its controller
// assumes one 100 MHz clock common to both ends
package pbs_pkg;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int WORD_W = 36;
    localparam int DEPTH = 2097152;
    localparam logic [2:0] CS_ACTIVE = 3'h2;
    localparam logic [2:0] CS_IDLE = 3'h5;
    localparam logic [3:0] BLS_NONE = 4'hF;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_STEP = 2'h1;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLEEP_REC_NS = 20;
    localparam int SLEEP_REC_CYC =
        (SLEEP_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DRAIN_CYC = 3;
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_READ,
        OP_WRITE
    } pbs_op_t;
    typedef enum logic [1:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_NEXT,
        CMD_DESELECT
    } pbs_cmd_t;
    typedef enum logic [1:0] {
        CS_RUN,
        CS_PREP,
        CS_SLEEP,
        CS_REC
    } pbs_cst_t;
endpackage : pbs_pkg

// ### verilog/pbs_if.sv
// pins between the burst memory device and its controller
// assumes both ends share clk; resolves the shared data and parity wires
`timescale 1ns/1ps
interface pbs_if;
    logic [pbs_pkg::ADDR_W-1:0] addr;
    logic [2:0] chip_selects;
    logic load_or_advance;
    logic write_strobe_n;
    logic [pbs_pkg::LANES-1:0] byte_lane_selects_n;
    logic clock_qualifier_n;
    logic output_drive_enable_n;
    logic burst_order;
    logic sleep_request;
    logic [pbs_pkg::DATA_W-1:0] data_dev_o;
    logic [pbs_pkg::LANES-1:0] parity_dev_o;
    logic dev_oe;
    logic [pbs_pkg::DATA_W-1:0] data_ctl_o;
    logic [pbs_pkg::LANES-1:0] parity_ctl_o;
    logic ctl_oe;
    logic [pbs_pkg::DATA_W-1:0] data_bus;
    logic [pbs_pkg::LANES-1:0] parity_lines;

    // undriven wires read as zero
    assign data_bus = dev_oe ? data_dev_o : (ctl_oe ? data_ctl_o : '0);
    assign parity_lines = dev_oe ? parity_dev_o :
        (ctl_oe ? parity_ctl_o : '0);

    modport dev (
        input addr, chip_selects, load_or_advance, write_strobe_n,
        input byte_lane_selects_n, clock_qualifier_n,
        input output_drive_enable_n, burst_order, sleep_request,
        input data_bus, parity_lines,
        output data_dev_o, parity_dev_o, dev_oe
    );
    modport ctl (
        output addr, chip_selects, load_or_advance, write_strobe_n,
        output byte_lane_selects_n, clock_qualifier_n,
        output output_drive_enable_n, burst_order, sleep_request,
        input data_bus, parity_lines,
        output data_ctl_o, parity_ctl_o, ctl_oe
    );
endinterface : pbs_if

// ### verilog/pbs_device.sv
// synchronous pipelined burst memory: control, burst counter and array
// assumes the controller end drives the pbs_if pins from the same clk
// assumes array contents need no reset; sleep gates the pins and drops pending accesses
`timescale 1ns/1ps
module pbs_device (
    input wire logic clk,
    input wire logic nrst,
    pbs_if.dev link
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        pbs_pkg::pbs_op_t a_op;
        logic [pbs_pkg::ADDR_W-1:0] a_addr;
        logic [1:0] a_start;
        logic [1:0] a_cnt;
        logic [pbs_pkg::LANES-1:0] a_bls;
        pbs_pkg::pbs_op_t b_op;
        logic [pbs_pkg::ADDR_W-1:0] b_addr;
        logic [pbs_pkg::LANES-1:0] b_bls;
        logic [pbs_pkg::WORD_W-1:0] b_rdata;
    } pbs_dev_st_t;

    typedef enum logic [2:0] {
        CY_HOLD,
        CY_SLEEP,
        CY_READ,
        CY_WRITE,
        CY_DESEL,
        CY_NEXT,
        CY_IDLE_ADV
    } pbs_dev_cyc_t;

    pbs_dev_st_t q;
    pbs_dev_st_t d;
    logic [pbs_pkg::WORD_W-1:0] mem [pbs_pkg::DEPTH];
    logic [pbs_pkg::WORD_W-1:0] old_word;
    logic [pbs_pkg::WORD_W-1:0] rd_raw;
    logic [pbs_pkg::WORD_W-1:0] rd_word;
    logic [pbs_pkg::DATA_W-1:0] wr_data;
    logic [pbs_pkg::LANES-1:0] wr_par;
    logic [pbs_pkg::DATA_W-1:0] fw_data;
    logic [pbs_pkg::LANES-1:0] fw_par;
    logic [pbs_pkg::WORD_W-1:0] wr_word;
    logic [1:0] next_cnt;
    logic [1:0] next_low;
    logic fwd;
    logic write_now;
    logic sel_ok;
    logic any_lane;
    pbs_dev_cyc_t cyc;

    assign old_word = mem[q.b_addr];
    assign rd_raw = mem[q.a_addr];
    assign fwd = (q.b_op == pbs_pkg::OP_WRITE) && (q.b_addr == q.a_addr);
    assign sel_ok = link.chip_selects == pbs_pkg::CS_ACTIVE;
    // all lanes off leaves the array alone
    assign any_lane = ~&q.b_bls;
    assign write_now = !q.sync2 && !link.clock_qualifier_n &&
        (q.b_op == pbs_pkg::OP_WRITE) && any_lane;

    // per-lane merge of bus data with stored word
    for (genvar i = 0; i < pbs_pkg::LANES; i++) begin : g_lane
        assign wr_data[i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] =
            q.b_bls[i] ? old_word[i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W]
                       : link.data_bus[i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W];
        assign wr_par[i] = q.b_bls[i] ? old_word[pbs_pkg::DATA_W+i]
                                      : link.parity_lines[i];
        assign fw_data[i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] =
            (fwd && !q.b_bls[i])
                ? link.data_bus[i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W]
                : rd_raw[i*pbs_pkg::LANE_W +: pbs_pkg::LANE_W];
        assign fw_par[i] = (fwd && !q.b_bls[i]) ? link.parity_lines[i]
                                                : rd_raw[pbs_pkg::DATA_W+i];
    end

    assign wr_word = {wr_par, wr_data};
    assign rd_word = {fw_par, fw_data};

    // next burst beat
    always_comb begin
        next_cnt = q.a_cnt + pbs_pkg::BEAT_STEP;
        if (link.burst_order) begin
            next_low = q.a_start ^ next_cnt;
        end else begin
            next_low = q.a_start + next_cnt;
        end
    end

    // classify the edge seen by the control pipeline
    always_comb begin
        if (q.sync2) begin
            cyc = CY_SLEEP;
        end else if (link.clock_qualifier_n) begin
            cyc = CY_HOLD;
        end else if (link.load_or_advance) begin
            if (q.a_op != pbs_pkg::OP_IDLE) begin
                cyc = CY_NEXT;
            end else begin
                cyc = CY_IDLE_ADV;
            end
        end else if (!sel_ok) begin
            cyc = CY_DESEL;
        end else if (link.write_strobe_n) begin
            cyc = CY_READ;
        end else begin
            cyc = CY_WRITE;
        end
    end

    always_comb begin
        d = q;
        d.sync1 = link.sleep_request;
        d.sync2 = q.sync1;
        // stage b follows stage a on every qualified edge outside sleep
        if (cyc != CY_SLEEP && cyc != CY_HOLD) begin
            d.b_op = q.a_op;
            d.b_addr = q.a_addr;
            d.b_bls = q.a_bls;
            if (q.a_op == pbs_pkg::OP_READ) begin
                d.b_rdata = rd_word;
            end
        end
        case (cyc)
            CY_SLEEP: begin
                // pending accesses dropped
                d.a_op = pbs_pkg::OP_IDLE;
                d.b_op = pbs_pkg::OP_IDLE;
            end
            CY_HOLD: begin
                // edge ignored, all state but the sleep synchronizer held
            end
            CY_READ: begin
                d.a_op = pbs_pkg::OP_READ;
                d.a_addr = link.addr;
                d.a_start = link.addr[1:0];
                d.a_cnt = pbs_pkg::BEAT_FIRST;
                d.a_bls = link.byte_lane_selects_n;
            end
            CY_WRITE: begin
                // no lanes selected still starts a write burst
                d.a_op = pbs_pkg::OP_WRITE;
                d.a_addr = link.addr;
                d.a_start = link.addr[1:0];
                d.a_cnt = pbs_pkg::BEAT_FIRST;
                d.a_bls = link.byte_lane_selects_n;
            end
            CY_NEXT: begin
                // type kept, chip selects and strobe ignored, lane selects taken
                d.a_cnt = next_cnt;
                d.a_addr[1:0] = next_low;
                d.a_bls = link.byte_lane_selects_n;
            end
            CY_DESEL: begin
                d.a_op = pbs_pkg::OP_IDLE;
            end
            default: begin
                d.a_op = pbs_pkg::OP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // array has no reset; sleep never touches it
    always_ff @(posedge clk) begin
        if (write_now) begin
            mem[q.b_addr] <= wr_word;
        end
    end

    // drive only for reads; enable acts without sampling
    assign link.dev_oe = (q.b_op == pbs_pkg::OP_READ) && !q.sync2 &&
        !link.output_drive_enable_n;
    assign link.data_dev_o = q.b_rdata[pbs_pkg::DATA_W-1:0];
    assign link.parity_dev_o = q.b_rdata[pbs_pkg::WORD_W-1:pbs_pkg::DATA_W];
endmodule : pbs_device

// ### verilog/pbs_controller.sv
// controller end: drives the memory pins from user commands
// assumes the device end shares clk and mirrors its pipeline here
`timescale 1ns/1ps
module pbs_controller (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire pbs_pkg::pbs_cmd_t cmd_op,
    input wire logic [pbs_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [pbs_pkg::LANES-1:0] cmd_bls_n,
    input wire logic [pbs_pkg::WORD_W-1:0] cmd_wdata,
    output logic cmd_ready,
    input wire logic user_hold,
    input wire logic user_sleep,
    input wire logic burst_order_sel,
    output logic rsp_valid,
    output logic [pbs_pkg::WORD_W-1:0] rsp_data,
    output logic sleeping,
    pbs_if.ctl link
);
    typedef struct packed {
        pbs_pkg::pbs_cst_t st;
        logic [1:0] cnt;
        logic [pbs_pkg::ADDR_W-1:0] addr;
        logic [2:0] cs;
        logic ld;
        logic we_n;
        logic [pbs_pkg::LANES-1:0] bls;
        logic cen_n;
        logic order;
        logic sleep;
        logic [pbs_pkg::WORD_W-1:0] w0;
        pbs_pkg::pbs_op_t p1_op;
        logic [pbs_pkg::WORD_W-1:0] p1_data;
        pbs_pkg::pbs_op_t p2_op;
        logic [pbs_pkg::WORD_W-1:0] p2_data;
        logic rsp_valid;
        logic [pbs_pkg::WORD_W-1:0] rsp_data;
    } pbs_ctl_st_t;

    pbs_ctl_st_t q;
    pbs_ctl_st_t d;

    assign cmd_ready = (q.st == pbs_pkg::CS_RUN) && !user_sleep && !user_hold;

    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;
        d.order = burst_order_sel;
        // mirror of the device pipeline
        if (q.st == pbs_pkg::CS_SLEEP) begin
            d.p1_op = pbs_pkg::OP_IDLE;
            d.p2_op = pbs_pkg::OP_IDLE;
        end else if (!q.cen_n) begin
            d.p2_op = q.p1_op;
            d.p2_data = q.p1_data;
            if (q.p2_op == pbs_pkg::OP_READ) begin
                d.rsp_valid = 1'b1;
                d.rsp_data = {link.parity_lines, link.data_bus};
            end
            if (!q.ld) begin
                if (q.cs != pbs_pkg::CS_ACTIVE) begin
                    d.p1_op = pbs_pkg::OP_IDLE;
                end else if (q.we_n) begin
                    d.p1_op = pbs_pkg::OP_READ;
                end else begin
                    d.p1_op = pbs_pkg::OP_WRITE;
                end
            end
            d.p1_data = q.w0;
        end
        case (q.st)
            pbs_pkg::CS_RUN: begin
                d.cen_n = user_hold;
                if (user_sleep) begin
                    d.cen_n = 1'b0;
                    d.cs = pbs_pkg::CS_IDLE;
                    d.ld = 1'b0;
                    d.st = pbs_pkg::CS_PREP;
                    d.cnt = 2'(pbs_pkg::DRAIN_CYC);
                end else if (!user_hold) begin
                    d.cs = pbs_pkg::CS_IDLE;
                    d.ld = 1'b0;
                    if (cmd_valid) begin
                        d.bls = cmd_bls_n;
                        d.w0 = cmd_wdata;
                        case (cmd_op)
                            pbs_pkg::CMD_READ: begin
                                d.cs = pbs_pkg::CS_ACTIVE;
                                d.we_n = 1'b1;
                                d.addr = cmd_addr;
                            end
                            pbs_pkg::CMD_WRITE: begin
                                d.cs = pbs_pkg::CS_ACTIVE;
                                d.we_n = 1'b0;
                                d.addr = cmd_addr;
                            end
                            pbs_pkg::CMD_NEXT: begin
                                d.ld = 1'b1;
                            end
                            default: begin
                                d.cs = pbs_pkg::CS_IDLE;
                            end
                        endcase
                    end
                end
            end
            pbs_pkg::CS_PREP: begin
                if (q.cnt == 2'h0) begin
                    d.sleep = 1'b1;
                    d.st = pbs_pkg::CS_SLEEP;
                end else begin
                    d.cnt = q.cnt - 2'h1;
                end
            end
            pbs_pkg::CS_SLEEP: begin
                if (!user_sleep) begin
                    d.sleep = 1'b0;
                    d.st = pbs_pkg::CS_REC;
                    d.cnt = 2'(pbs_pkg::SLEEP_REC_CYC);
                end
            end
            default: begin
                // selects stay idle through recovery
                d.cnt = q.cnt - 2'h1;
                if (q.cnt == 2'h1) begin
                    d.st = pbs_pkg::CS_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.cs <= pbs_pkg::CS_IDLE;
            q.we_n <= 1'b1;
            q.bls <= pbs_pkg::BLS_NONE;
        end else begin
            q <= d;
        end
    end

    assign link.addr = q.addr;
    assign link.chip_selects = q.cs;
    assign link.load_or_advance = q.ld;
    assign link.write_strobe_n = q.we_n;
    assign link.byte_lane_selects_n = q.bls;
    assign link.clock_qualifier_n = q.cen_n;
    assign link.burst_order = q.order;
    assign link.sleep_request = q.sleep;
    // enable off while own write data is out
    assign link.output_drive_enable_n = (q.p2_op == pbs_pkg::OP_WRITE);
    assign link.ctl_oe = (q.p2_op == pbs_pkg::OP_WRITE) && !q.sleep;
    assign link.data_ctl_o = q.p2_data[pbs_pkg::DATA_W-1:0];
    assign link.parity_ctl_o = q.p2_data[pbs_pkg::WORD_W-1:pbs_pkg::DATA_W];
    assign rsp_valid = q.rsp_valid;
    assign rsp_data = q.rsp_data;
    assign sleeping = (q.st == pbs_pkg::CS_SLEEP);
endmodule : pbs_controller

// ### testbench/pbs_link_sva.sv
// checker on the pins joining the burst memory device and controller
// assumes it sits beside the pbs_if that joins the two ends
`timescale 1ns/1ps
module pbs_link_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] chip_selects,
    input wire logic load_or_advance,
    input wire logic write_strobe_n,
    input wire logic clock_qualifier_n,
    input wire logic output_drive_enable_n,
    input wire logic sleep_request,
    input wire logic [pbs_pkg::DATA_W-1:0] data_dev_o,
    input wire logic dev_oe,
    input wire logic ctl_oe
);
    logic sel;
    logic start;
    assign sel = chip_selects == pbs_pkg::CS_ACTIVE;
    assign start = !clock_qualifier_n && !sleep_request && !load_or_advance;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_read_drive: assert property (
        start && sel && write_strobe_n ##1 !clock_qualifier_n
        |=> dev_oe == !output_drive_enable_n)
        else $error("read data not driven after capture");
    a_write_quiet: assert property (
        start && sel && !write_strobe_n ##1 !clock_qualifier_n |=> !dev_oe)
        else $error("device drives during write data");
    a_no_clash: assert property (ctl_oe |-> !dev_oe)
        else $error("both ends drive the data lines");
    a_oe_gate: assert property (output_drive_enable_n |-> !dev_oe)
        else $error("device drives with drive enable off");
    a_sleep_quiet: assert property (sleep_request [*3] |-> !dev_oe)
        else $error("device drives while asleep");
    a_desel_pipe: assert property (
        start && !sel ##1 !clock_qualifier_n |=> !dev_oe)
        else $error("deselect did not tri-state");
    a_adv_idle: assert property (
        start && !sel ##1 (!clock_qualifier_n && load_or_advance)
        |-> ##2 !dev_oe)
        else $error("advance while deselected drove data");
    a_stall_hold: assert property (
        clock_qualifier_n && !sleep_request |=> $stable(data_dev_o))
        else $error("stalled edge changed output data");
    a_sleep_desel: assert property (
        $rose(sleep_request)
        |-> !sel && $past(chip_selects) != pbs_pkg::CS_ACTIVE)
        else $error("sleep raised while selected");
    a_wake_idle: assert property ($fell(sleep_request) |-> !sel [*2])
        else $error("selected too soon after sleep");
    a_reset_quiet: assert property (
        $rose(nrst) |-> !dev_oe && chip_selects == pbs_pkg::CS_IDLE)
        else $error("not deselected after reset");
endmodule : pbs_link_sva

// ### testbench/pipelined_burst_sram_control_tb_top.sv
// bench for the burst memory device and controller joined back to back
// assumes pbs_pkg, pbs_if and both design ends are compiled first
`timescale 1ns/1ps
`define CHK(nm, ex, gt) chk(nm, 64'(ex), 64'(gt));
module pipelined_burst_sram_control_tb_top;
    logic clk, nrst, cmd_valid, user_hold, user_sleep, order, rdy_s;
    logic cmd_ready, rsp_valid, sleeping;
    pbs_pkg::pbs_cmd_t cmd_op;
    logic [pbs_pkg::ADDR_W-1:0] cmd_addr;
    logic [3:0] cmd_bls_n;
    logic [35:0] cmd_wdata, rsp_data;
    logic [35:0] mem [logic [20:0]];
    logic [35:0] eq [$];
    logic [35:0] rq [$];
    int mismatches, check_count;
    pbs_if link ();
    pbs_device pbs_device_i (.clk(clk), .nrst(nrst), .link(link));
    pbs_controller pbs_controller_i (.clk(clk), .nrst(nrst),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_bls_n(cmd_bls_n), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .user_hold(user_hold),
        .user_sleep(user_sleep), .burst_order_sel(order),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .sleeping(sleeping), .link(link));
    pbs_link_sva pbs_link_sva_i (.clk(clk), .nrst(nrst),
        .chip_selects(link.chip_selects),
        .load_or_advance(link.load_or_advance),
        .write_strobe_n(link.write_strobe_n),
        .clock_qualifier_n(link.clock_qualifier_n),
        .output_drive_enable_n(link.output_drive_enable_n),
        .sleep_request(link.sleep_request), .data_dev_o(link.data_dev_o),
        .dev_oe(link.dev_oe), .ctl_oe(link.ctl_oe));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        rdy_s = cmd_ready;
        if (rsp_valid === 1'b1) rq.push_back(rsp_data);
    end
    task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    task automatic cmd(pbs_pkg::pbs_cmd_t op, logic [20:0] a,
        logic [3:0] b, logic [35:0] w);
        int n;
        n = 0;
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_bls_n <= b;
        cmd_wdata <= w;
        @(posedge clk);
        while (rdy_s !== 1'b1) begin
            n++;
            if (n > 200) begin
                mismatches++;
                test_done();
            end
            @(posedge clk);
        end
    endtask : cmd
    // four beats from one address, optional stall before the third beat
    task automatic burst(bit wr, logic [20:0] a, logic [15:0] bl, bit st);
        logic [20:0] an;
        logic [35:0] w;
        for (int n = 0; n < 4; n++) begin
            an = {a[20:2], order ? a[1:0] ^ 2'(n) : a[1:0] + 2'(n)};
            w = {bl[3:0] ^ 4'(n), an[15:0], an[15:0] ^ bl};
            if (st && n == 2) begin
                user_hold <= 1'b1;
                repeat (3) @(posedge clk);
                user_hold <= 1'b0;
            end
            if (n > 0) cmd(pbs_pkg::CMD_NEXT, a, bl[4*n+:4], w);
            else cmd(wr ? pbs_pkg::CMD_WRITE : pbs_pkg::CMD_READ, a, bl[3:0], w);
            for (int i = 0; i < 4; i++) begin
                if (wr && !bl[4*n+i]) begin
                    mem[an][8*i+:8] = w[8*i+:8];
                    mem[an][32+i] = w[32+i];
                end
            end
            if (!wr) eq.push_back(mem[an]);
        end
    endtask : burst
    task automatic drain();
        cmd_valid <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK("responses", eq.size(), rq.size())
        while (eq.size() > 0 && rq.size() > 0) begin
            `CHK("read word", eq.pop_front(), rq.pop_front())
        end
        eq.delete();
        rq.delete();
    endtask : drain
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        test_done();
    end
    initial begin
        nrst = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = pbs_pkg::CMD_DESELECT;
        cmd_addr = '0;
        cmd_bls_n = pbs_pkg::BLS_NONE;
        cmd_wdata = '0;
        user_hold = 1'b0;
        user_sleep = 1'b0;
        order = 1'b0;
        mismatches = 0;
        check_count = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        `CHK("reset selects", pbs_pkg::CS_IDLE, link.chip_selects)
        `CHK("reset drive", 1'b0, link.dev_oe)
        @(posedge clk);
        for (int o = 0; o < 2; o++) begin
            order <= o[0];
            burst(1'b1, 21'h000101 + 21'(o * 16), 16'h0000, 1'b0);
            burst(1'b0, 21'h000101 + 21'(o * 16), 16'hFFFF, 1'b1);
            burst(1'b1, 21'h000101 + 21'(o * 16), 16'h0FA5, 1'b1);
            burst(1'b0, 21'h000101 + 21'(o * 16), 16'hFFFF, 1'b0);
            drain();
        end
        user_sleep <= 1'b1;
        for (int i = 0; i < 50 && sleeping !== 1'b1; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK("sleep pin", 1'b1, link.sleep_request)
        `CHK("sleeping", 1'b1, sleeping)
        `CHK("sleep drive", 1'b0, link.dev_oe)
        `CHK("sleep bus", 36'h0, {link.parity_lines, link.data_bus})
        `CHK("sleep selects", pbs_pkg::CS_IDLE, link.chip_selects)
        @(posedge clk);
        user_sleep <= 1'b0;
        burst(1'b0, 21'h000101, 16'hFFFF, 1'b0);
        cmd(pbs_pkg::CMD_DESELECT, '0, pbs_pkg::BLS_NONE, '0);
        burst(1'b0, 21'h000111, 16'hFFFF, 1'b0);
        cmd(pbs_pkg::CMD_WRITE, 21'h000200, 4'h0, 36'h9_1234_5678);
        cmd(pbs_pkg::CMD_READ, 21'h000200, 4'hF, '0);
        eq.push_back(36'h9_1234_5678);
        cmd(pbs_pkg::CMD_DESELECT, '0, pbs_pkg::BLS_NONE, '0);
        cmd(pbs_pkg::CMD_NEXT, '0, pbs_pkg::BLS_NONE, '0);
        drain();
        test_done();
    end
endmodule : pipelined_burst_sram_control_tb_top
